// File: triple_channel_monitor_config.sv
// Operation
// - Reset leaves the configuration word at 7127h.
// - Reading the configuration word changes no setting and does not disturb a running conversion.
// - A configuration write freezes conversion until the transfer ends, then a new pass starts.
// - Writing one to bit 15 restores every register to its default and the bit reads back zero.
// - Bits 14, 13, 12 enable channels one, two and three.
// - Bits 11-9 pick 1, 4, 16, 64, 128, 256, 512 or 1024 samples per result.
// - Bits 8-6 pick the bus conversion time from 140 us up to 8.244 ms.
// - Bits 5-3 pick the shunt conversion time from the same table.
// - Mode codes 000 and 100 power the converter down.
// - Mode codes 001, 010, 011 run one pass of shunt, bus, or both.
// - Mode codes 101, 110, 111 repeat passes of shunt, bus, or both.
// - Each 16-bit word moves as two bytes, high byte first.
`timescale 1ns/1ps
module triple_channel_monitor_config
  import monitor_pkg::*;
#(
  parameter int          CONV_CYCLES [8] = '{`CT_CYCLES(`CT0_TIME_US), `CT_CYCLES(`CT1_TIME_US),
                                             `CT_CYCLES(`CT2_TIME_US), `CT_CYCLES(`CT3_TIME_US),
                                             `CT_CYCLES(`CT4_TIME_US), `CT_CYCLES(`CT5_TIME_US),
                                             `CT_CYCLES(`CT6_TIME_US), `CT_CYCLES(`CT7_TIME_US)},
  parameter logic [15:0] MAKER_CODE      = 16'hA5C3, // Arbitrary value
  parameter logic [15:0] SILICON_CODE    = 16'h0F1E  // Arbitrary value
) (
  input  wire logic       ref_clk,     // Core clock, 250 MHz
  input  wire logic       rst_n,       // Async reset, active low
  input  wire logic [6:0] dev_addr,    // Own bus address
  input  wire logic       scl_in,      // Serial clock level
  input  wire logic       sda_in,      // Serial data level
  output logic            sda_out,     // Data drive value
  output logic            sda_oe,      // Data drive enable
  output logic            conv_active, // A conversion is running
  output logic      [1:0] conv_chan,   // Channel being converted, 0..2
  output logic            conv_bus,    // High: bus voltage, low: shunt
  output logic            sample_done, // One sample finished, pulse
  output logic            pass_done    // One pass over all slots, pulse
);
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_first;
  logic [7:0]  tx_data;
  logic        tx_take;
  logic        wr_active;
  logic        xfer_end;
  logic [7:0]  ptr;
  logic        wr_phase;
  logic        rd_phase;
  logic [7:0]  hold_byte;
  logic        wr_commit;
  logic [15:0] wr_word;
  logic [15:0] cfg;
  logic        soft_rst;
  logic [15:0] mask_ctl;
  logic        conv_ready;
  logic [15:0] lim_rdata;
  logic [15:0] rd_word;
  logic        cfg_hold;
  logic        cfg_dirty;
  logic        restart;
  seq_state_t  seq;
  logic [2:0]  slot;
  logic [21:0] timer;
  logic [10:0] samples;
  logic [2:0]  ct_sel;
  logic        timer_end;
  logic        last_sample;
  logic        cfg_write;

  serial_target link (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .dev_addr  (dev_addr),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .rx_valid  (rx_valid),
    .rx_data   (rx_data),
    .rx_first  (rx_first),
    .tx_data   (tx_data),
    .tx_take   (tx_take),
    .wr_active (wr_active),
    .xfer_end  (xfer_end)
  );

  limit_store limits (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .clear (soft_rst),
    .we    (wr_commit && limit_hit(ptr)),
    .waddr (limit_index(ptr)),
    .wdata (wr_word),
    .raddr (limit_index(ptr)),
    .rdata (lim_rdata)
  );

  // Slot enabled: channel enable bit and shunt or bus selection
  function automatic logic slot_on(input logic [2:0] s, input logic [15:0] c);
    slot_on = c[`CFG_CHAN_HI - s[2:1]] && (s[0] ? c[`OP_BUS_BIT] : c[`OP_SHUNT_BIT]);
  endfunction : slot_on

  assign cfg_write   = wr_commit && ptr == `ADDR_CONFIG;
  assign restart     = xfer_end && cfg_dirty;
  assign ct_sel      = slot[0] ? cfg[`CFG_BUS_CT_HI:`CFG_BUS_CT_LO] : cfg[`CFG_SH_CT_HI:`CFG_SH_CT_LO];
  assign timer_end   = timer == 22'(CONV_CYCLES[ct_sel] - 1);
  assign last_sample = samples == avg_samples(cfg[`CFG_AVG_HI:`CFG_AVG_LO]) - 11'h001;
  assign conv_active = (seq == s_conv);
  assign conv_chan   = slot[2:1];
  assign conv_bus    = slot[0];

  // Pointer and byte pairing; an odd high byte is dropped at transfer end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr       <= `ADDR_CONFIG;
      wr_phase  <= 1'b0;
      rd_phase  <= 1'b0;
      hold_byte <= 8'h00;
      wr_commit <= 1'b0;
      wr_word   <= 16'h0000;
    end else begin
      wr_commit <= 1'b0;
      if (xfer_end) begin
        wr_phase <= 1'b0;
        rd_phase <= 1'b0;
      end else if (rx_valid && rx_first) begin
        ptr      <= rx_data;
        wr_phase <= 1'b0;
      end else if (rx_valid && !wr_phase) begin
        hold_byte <= rx_data;
        wr_phase  <= 1'b1;
      end else if (rx_valid) begin
        wr_word   <= {hold_byte, rx_data};
        wr_commit <= 1'b1;
        wr_phase  <= 1'b0;
      end else if (tx_take) begin
        rd_phase <= !rd_phase;
      end
    end
  end

  // Configuration word; soft reset bit restores defaults and never sticks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg      <= `CFG_RESET;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= cfg_write && wr_word[`CFG_SOFT_RESET];
      if (cfg_write) begin
        cfg <= wr_word[`CFG_SOFT_RESET] ? `CFG_RESET : {1'b0, wr_word[14:0]};
      end
    end
  end

  // Alert mask word: control bits stored, ready flag set by each pass
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ctl   <= `RST_MASK;
      conv_ready <= 1'b0;
    end else begin
      if (soft_rst) begin
        mask_ctl <= `RST_MASK;
      end else if (wr_commit && ptr == `ADDR_ALERT_MASK) begin
        mask_ctl <= wr_word & `MASK_WRITABLE;
      end
      // Set wins over the read that clears it
      if (pass_done) begin
        conv_ready <= 1'b1;
      end else if (soft_rst || (tx_take && !rd_phase && ptr == `ADDR_ALERT_MASK)) begin
        conv_ready <= 1'b0;
      end
    end
  end

  // Read mux; reading has no side effect on configuration
  always_comb begin
    rd_word = 16'h0000;
    if (ptr == `ADDR_CONFIG) begin
      rd_word = {1'b0, cfg[14:0]};
    end else if (ptr == `ADDR_ALERT_MASK) begin
      rd_word = mask_ctl | {15'h0000, conv_ready};
    end else if (ptr == `ADDR_MAKER) begin
      rd_word = MAKER_CODE;
    end else if (ptr == `ADDR_SILICON) begin
      rd_word = SILICON_CODE;
    end else if (limit_hit(ptr)) begin
      rd_word = lim_rdata;
    end
  end

  // Byte offered to the link, high byte first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data <= 8'h00;
    end else begin
      tx_data <= rd_phase ? rd_word[7:0] : rd_word[15:8];
    end
  end

  // Freeze while a configuration write is open; restart only if it landed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_hold  <= 1'b0;
      cfg_dirty <= 1'b0;
    end else begin
      if (rx_valid && rx_first && rx_data == `ADDR_CONFIG) begin
        cfg_hold <= 1'b1;
      end else if (xfer_end) begin
        cfg_hold <= 1'b0;
      end
      if (cfg_write) begin
        cfg_dirty <= 1'b1;
      end else if (xfer_end) begin
        cfg_dirty <= 1'b0;
      end
    end
  end

  // Conversion sequencer over six slots: ch1 shunt, ch1 bus, ... ch3 bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq         <= s_seek;
      slot        <= 3'h0;
      timer       <= 22'h000000;
      samples     <= 11'h000;
      sample_done <= 1'b0;
      pass_done   <= 1'b0;
    end else begin
      sample_done <= 1'b0;
      pass_done   <= 1'b0;
      if (restart) begin
        seq     <= s_seek;
        slot    <= 3'h0;
        timer   <= 22'h000000;
        samples <= 11'h000;
      end else if (!cfg_hold) begin
        case (seq)
          s_seek: begin
            if (cfg[`OP_BUS_BIT:`OP_SHUNT_BIT] == 2'h0) begin
              seq <= s_off;
            end else if (slot == `SLOT_END) begin
              pass_done <= 1'b1;
              slot      <= 3'h0;
              seq       <= cfg[`OP_CONT_BIT] ? s_seek : s_idle;
            end else if (slot_on(slot, cfg)) begin
              seq     <= s_conv;
              timer   <= 22'h000000;
              samples <= 11'h000;
            end else begin
              slot <= slot + 3'h1;
            end
          end
          s_conv: begin
            if (timer_end) begin
              timer       <= 22'h000000;
              sample_done <= 1'b1;
              if (last_sample) begin
                slot <= slot + 3'h1;
                seq  <= s_seek;
              end else begin
                samples <= samples + 11'h001;
              end
            end else begin
              timer <= timer + 22'h000001;
            end
          end
          s_off:   seq <= s_off;
          s_idle:  seq <= s_idle;
          default: seq <= s_seek;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_pass_end;
    seq == s_seek && slot == `SLOT_END && cfg[1:0] != 2'h0 && !cfg_hold && !restart;
  endsequence
  sequence seq_idle_two;
    seq == s_idle ##1 seq == s_idle;
  endsequence

  // The soft reset strobe lasts one cycle; the mask word shows its effect one cycle after it
  soft_reset_cfg_a: assert property (cfg_write && wr_word[15] |=> cfg == `CFG_RESET && !cfg[15] && soft_rst
                                     ##1 mask_ctl == `RST_MASK)
    else $error("soft reset did not restore configuration");
  cfg_write_apply_a: assert property (cfg_write && !wr_word[15] |=> cfg[14:0] == $past(wr_word[14:0]))
    else $error("configuration write not applied");
  // The sequencer keeps walking during a read, so only an early end of a sample counts as a disturbance
  read_no_effect_a: assert property (tx_take && ptr == `ADDR_CONFIG && !cfg_write && !restart
                                     |=> $stable(cfg) && (conv_active || !$past(conv_active) || $past(timer_end)))
    else $error("configuration read disturbed state");
  hold_freeze_a: assert property (cfg_hold && !restart |=> $stable(timer) && $stable(slot))
    else $error("conversion ran during configuration write");
  write_restart_a: assert property (restart |=> seq == s_seek && slot == 3'h0 && timer == 22'h000000)
    else $error("no fresh pass after configuration write");
  power_down_a: assert property (seq == s_seek && cfg[1:0] == 2'h0 && !cfg_hold && !restart |=> seq == s_off)
    else $error("power-down code did not stop conversion");
  single_idle_a: assert property (seq_pass_end and !cfg[2] |=> pass_done ##0 seq_idle_two)
    else $error("single pass did not go idle");
  cont_repeat_a: assert property (seq_pass_end and cfg[2] |=> pass_done && seq == s_seek && slot == 3'h0)
    else $error("continuous mode did not repeat");
  sample_avg_a: assert property (seq == s_conv && timer_end && last_sample && !cfg_hold && !restart
                                 |=> seq == s_seek && slot == $past(slot) + 3'h1)
    else $error("slot ended at wrong sample count");
  conv_timer_a: assert property (seq == s_conv && !timer_end && !cfg_hold && !restart
                                 |=> timer == $past(timer) + 22'h000001 && !sample_done)
    else $error("conversion timer misbehaved");
  byte_pair_a: assert property (wr_commit |-> $past(rx_valid) && $past(wr_phase))
    else $error("word committed without byte pair");
endmodule : triple_channel_monitor_config

// File: monitor_regs.svh
`ifndef MONITOR_REGS_SVH
`define MONITOR_REGS_SVH

// Register pointer values
`define ADDR_CONFIG       8'h00
`define ADDR_CH1_FAULT    8'h07
`define ADDR_TOTAL_LIMIT  8'h0E
`define ADDR_SHUNT_TOTAL  8'h0D
`define ADDR_ALERT_MASK   8'h0F
`define ADDR_GOOD_HIGH    8'h10
`define ADDR_GOOD_LOW     8'h11
`define ADDR_MAKER        8'hFE
`define ADDR_SILICON      8'hFF

// Configuration word layout
`define CFG_RESET         16'h7127
`define CFG_SOFT_RESET    15
`define CFG_CHAN_HI       14
`define CFG_AVG_HI        11
`define CFG_AVG_LO        9
`define CFG_BUS_CT_HI     8
`define CFG_BUS_CT_LO     6
`define CFG_SH_CT_HI      5
`define CFG_SH_CT_LO      3
`define OP_CONT_BIT       2
`define OP_BUS_BIT        1
`define OP_SHUNT_BIT      0

// Reset values and masks of the other writable words
`define RST_FAULT         16'h7FF8
`define RST_TOTAL_LIMIT   16'h7FFE
`define RST_GOOD_HIGH     16'h2710
`define RST_GOOD_LOW      16'h2328
`define RST_MASK          16'h0002
`define MASK_WRITABLE     16'h7C02
`define MASK_READY_BIT    0

// Conversion timing, slot end and limit word count
`define CLK_MHZ           250
`define CT0_TIME_US       140
`define CT1_TIME_US       204
`define CT2_TIME_US       332
`define CT3_TIME_US       588
`define CT4_TIME_US       1100
`define CT5_TIME_US       2116
`define CT6_TIME_US       4156
`define CT7_TIME_US       8244
`define CT_CYCLES(t)      ((t) * `CLK_MHZ)
`define SLOT_END          3'h6
`define LIMIT_WORDS       10

`endif

// File: monitor_pkg.sv
package monitor_pkg;
  `include "monitor_regs.svh"

  typedef enum logic [1:0] {s_off, s_seek, s_conv, s_idle} seq_state_t;
  typedef enum logic [2:0] {i_idle, i_addr, i_write, i_read, i_skip} link_state_t;

  // Samples per result for each averaging code
  function automatic logic [10:0] avg_samples(input logic [2:0] code);
    case (code)
      3'h0:    avg_samples = 11'h001;
      3'h1:    avg_samples = 11'h004;
      3'h2:    avg_samples = 11'h010;
      3'h3:    avg_samples = 11'h040;
      3'h4:    avg_samples = 11'h080;
      3'h5:    avg_samples = 11'h100;
      3'h6:    avg_samples = 11'h200;
      default: avg_samples = 11'h400;
    endcase
  endfunction : avg_samples

  // Writable limit words live in the store; the sum word is read-only
  function automatic logic limit_hit(input logic [7:0] addr);
    limit_hit = (addr >= `ADDR_CH1_FAULT && addr <= `ADDR_TOTAL_LIMIT && addr != `ADDR_SHUNT_TOTAL) ||
                addr == `ADDR_GOOD_HIGH || addr == `ADDR_GOOD_LOW;
  endfunction : limit_hit

  function automatic logic [3:0] limit_index(input logic [7:0] addr);
    logic [7:0] idx;
    idx = (addr >= `ADDR_GOOD_HIGH) ? addr - 8'h08 : addr - `ADDR_CH1_FAULT;
    limit_index = idx[3:0];
  endfunction : limit_index
endpackage : monitor_pkg

// File: limit_store.sv
`timescale 1ns/1ps
module limit_store
  import monitor_pkg::*;
(
  input  wire logic        clk,    // Core clock
  input  wire logic        rst_n,  // Async reset, active low
  input  wire logic        clear,  // Reload defaults
  input  wire logic        we,     // Write strobe
  input  wire logic [3:0]  waddr,  // Write index
  input  wire logic [15:0] wdata,  // Write word
  input  wire logic [3:0]  raddr,  // Read index
  output logic      [15:0] rdata   // Registered read word
);
  logic [15:0] words [`LIMIT_WORDS];

  // Default per index; index 6 is unused
  function automatic logic [15:0] word_default(input int i);
    case (i)
      7:       word_default = `RST_TOTAL_LIMIT;
      8:       word_default = `RST_GOOD_HIGH;
      9:       word_default = `RST_GOOD_LOW;
      6:       word_default = 16'h0000;
      default: word_default = `RST_FAULT;
    endcase
  endfunction : word_default

  // Storage with reset to defaults, also reachable by soft reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `LIMIT_WORDS; i++) words[i] <= word_default(i);
    end else if (clear) begin
      for (int i = 0; i < `LIMIT_WORDS; i++) words[i] <= word_default(i);
    end else if (we && waddr < 4'(`LIMIT_WORDS)) begin
      words[waddr] <= wdata;
    end
  end

  // Read port registered; out of range reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= (raddr < 4'(`LIMIT_WORDS)) ? words[raddr] : 16'h0000;
    end
  end
endmodule : limit_store

// File: serial_target.sv
`timescale 1ns/1ps
module serial_target
  import monitor_pkg::*;
(
  input  wire logic       clk,       // Core clock
  input  wire logic       rst_n,     // Async reset, active low
  input  wire logic [6:0] dev_addr,  // Own bus address
  input  wire logic       scl_in,    // Serial clock level
  input  wire logic       sda_in,    // Serial data level
  output logic            sda_out,   // Data drive value, always low
  output logic            sda_oe,    // Pull data low when high
  output logic            rx_valid,  // Byte written by host, pulse
  output logic      [7:0] rx_data,   // Written byte
  output logic            rx_first,  // Byte is the pointer byte
  input  wire logic [7:0] tx_data,   // Next byte to send
  output logic            tx_take,   // tx_data loaded, pulse
  output logic            wr_active, // Addressed for write
  output logic            xfer_end   // Stop or repeated start, pulse
);
  link_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  sr;
  logic [7:0]  tx_sr;
  logic        scl_q;
  logic        sda_q;
  logic        ack_go;
  logic        first;
  logic [7:0]  byte_in;
  logic        busy;

  assign sda_out   = 1'b0;
  assign wr_active = (state == i_write);
  assign byte_in   = {sr[6:0], sda_in};
  assign busy      = (state == i_write) || (state == i_read);

  // Previous line levels for edge and condition detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Bit engine: sample on rising clock, drive on falling clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= i_idle;
      bit_cnt  <= 4'h0;
      sr       <= 8'h00;
      tx_sr    <= 8'h00;
      sda_oe   <= 1'b0;
      ack_go   <= 1'b0;
      first    <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      rx_first <= 1'b0;
      tx_take  <= 1'b0;
      xfer_end <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      tx_take  <= 1'b0;
      xfer_end <= 1'b0;
      if (scl_in && scl_q && sda_q && !sda_in) begin
        state    <= i_addr;
        bit_cnt  <= 4'h0;
        sda_oe   <= 1'b0;
        ack_go   <= 1'b0;
        xfer_end <= busy;
      end else if (scl_in && scl_q && !sda_q && sda_in) begin
        state    <= i_idle;
        sda_oe   <= 1'b0;
        xfer_end <= busy;
      end else if (scl_in && !scl_q && state != i_idle && state != i_skip) begin
        if (bit_cnt < 4'h8) begin
          sr      <= byte_in;
          bit_cnt <= bit_cnt + 4'h1;
        end else begin
          bit_cnt <= 4'h9;
          if (state == i_read && sda_in) state <= i_skip; // Host declined more bytes
        end
        if (bit_cnt == 4'h7 && state == i_addr) begin
          if (byte_in[7:1] == dev_addr) begin
            ack_go <= 1'b1;
            first  <= 1'b1;
            state  <= byte_in[0] ? i_read : i_write;
          end else begin
            state <= i_skip;
          end
        end else if (bit_cnt == 4'h7 && state == i_write) begin
          rx_valid <= 1'b1;
          rx_data  <= byte_in;
          rx_first <= first;
          first    <= 1'b0;
          ack_go   <= 1'b1;
        end
      end else if (!scl_in && scl_q && state != i_idle && state != i_skip) begin
        if (bit_cnt == 4'h8) begin
          sda_oe <= ack_go;
        end else if (bit_cnt == 4'h9) begin
          bit_cnt <= 4'h0;
          ack_go  <= 1'b0;
          if (state == i_read) begin
            tx_sr   <= {tx_data[6:0], 1'b0};
            sda_oe  <= !tx_data[7];
            tx_take <= 1'b1;
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (state == i_read && bit_cnt != 4'h0) begin
          sda_oe <= !tx_sr[7];
          tx_sr  <= {tx_sr[6:0], 1'b0};
        end
      end
    end
  end
endmodule : serial_target

// File: serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model #(
  parameter logic [6:0] DEV = 7'h40 // Target address
) (
  input  wire logic        ref_clk,  // Pacing clock
  input  wire logic        sda,      // Resolved data wire
  output logic             scl,      // Serial clock
  output logic             sda_oe,   // Host pulls data low
  output logic             writing,  // Config write open
  output logic             rd_valid, // Word read, pulse
  output logic      [15:0] rd_word   // Word read
);
  localparam int PH = 5; // Above the four clocks a phase needs
  initial {scl, sda_oe, writing, rd_valid, rd_word} = 20'h80000;
  // Data moves while the clock is low, save start and stop
  task automatic hp(input logic c, input logic d);
    scl = c;
    sda_oe = d;
    repeat (PH) @(negedge ref_clk);
  endtask : hp
  // Start when s is high, stop when low
  task automatic frame(input logic s);
    hp(0, !s);
    hp(1, !s);
    hp(1, s);
  endtask : frame
  // Eight bits high first, then the acknowledge slot
  task automatic bytex(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      hp(0, !d[i]);
      hp(1, !d[i]);
      q[i] = sda;
    end
  endtask : bytex
  // Pointer and optional word, or a read at the pointer
  task automatic xfer(input logic rd, input logic [7:0] ptr, input logic [15:0] w, input logic data);
    logic [8:0] q;
    logic [8:0] h;
    writing = !rd && ptr == 8'h00;
    frame(1);
    bytex({DEV, rd, 1'b1}, q);
    if (rd) begin
      bytex(9'h1FE, h);
      bytex(9'h1FF, q);
      rd_word = {h[8:1], q[8:1]};
    end else begin
      bytex({ptr, 1'b1}, q);
      if (data) begin
        bytex({w[15:8], 1'b1}, q);
        bytex({w[7:0], 1'b1}, q);
      end
    end
    frame(0);
    writing = 0;
    rd_valid = rd;
    @(negedge ref_clk);
    rd_valid = 0;
  endtask : xfer
endmodule : serial_host_model

// File: triple_channel_monitor_config_tb.sv
`timescale 1ns/1ps
module triple_channel_monitor_config_tb;
  import monitor_pkg::*;
  localparam int CT [8] = '{10, 12, 14, 16, 20, 24, 28, 32}; // Short counts
  logic        ref_clk, rst_n, scl, h_oe, d_oe, writing, rd_valid;
  logic        conv_active, conv_bus, sample_done, pass_done, kind;
  logic [1:0]  conv_chan, chan;
  logic [15:0] rd_word;
  logic [15:0] cfg = 16'h7127;
  logic [31:0] lfsr = 32'h0E06;
  int          n_mismatch = 0, n_checks = 0, samples = 0, span = 0;
  logic [15:0] word_q[$];
  int          count_q[$];
  wire         sda = !(h_oe || d_oe); // Pull-up
  triple_channel_monitor_config #(.CONV_CYCLES(CT)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .dev_addr(7'h40), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(d_oe), .conv_active(conv_active),
    .conv_chan(conv_chan), .conv_bus(conv_bus), .sample_done(sample_done), .pass_done(pass_done));
  serial_host_model #(.DEV(7'h40)) host_u (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_oe(h_oe),
    .writing(writing), .rd_valid(rd_valid), .rd_word(rd_word));
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = !ref_clk;
  end
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_count(input string what, input int exp, input int got);
    check_word(what, 16'(exp), 16'(got));
  endtask : check_count
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : step
  // Read words meet the oldest note
  always @(posedge ref_clk) if (rd_valid && word_q.size() > 0) check_word("word", word_q.pop_front(), rd_word);
  // Sampled on the falling edge where outputs have settled; a run of conv_active measures one sample
  always @(negedge ref_clk) begin
    if (conv_active) {kind, chan} <= {conv_bus, conv_chan};
    span <= conv_active ? span + 1 : 0;
    samples <= (writing || pass_done) ? 0 : samples + sample_done;
    if (sample_done && !writing) begin
      check_count("clocks", kind ? CT[cfg[8:6]] : CT[cfg[5:3]], span);
      check_word("slot", 16'h1, {15'h0, (kind ? cfg[1] : cfg[0]) && cfg[14 - chan]});
      span <= int'(conv_active); // Next sample of the slot already running
    end
    if (pass_done && !writing && count_q.size() > 0) check_count("samples", count_q.pop_front(), samples);
  end
  task automatic put(input logic [15:0] w);
    host_u.xfer(0, 8'h00, w, 1);
    cfg = w[15] ? 16'h7127 : w;
  endtask : put
  task automatic rd();
    host_u.xfer(1, 8'h00, 16'h0, 0);
  endtask : rd
  // Converter must stay off for the next 200 clocks
  task automatic quiet();
    logic [15:0] busy;
    busy = 0;
    repeat (200) begin
      @(negedge ref_clk);
      busy = busy + conv_active;
    end
    check_word("idle", 16'h0, busy);
  endtask : quiet
  task automatic run(input logic [2:0] m);
    logic [15:0] w;
    int n;
    lfsr = step(lfsr);
    w = {1'b0, lfsr[14:12], 2'b0, lfsr[0], lfsr[8:3], m};
    n = $countones(w[14:12]) * (int'(m[0]) + int'(m[1])) * (w[9] ? 4 : 1);
    count_q.push_back(n);
    if (m[2]) count_q.push_back(n);
    put(w);
    word_q.push_back(w);
    rd();
    for (n = 0; n < 20000 && count_q.size() > 0; n++) @(negedge ref_clk);
    if (n == 20000) begin
      check_count("passes left", 0, count_q.size());
      results();
    end
    if (!m[2]) quiet();
  endtask : run
  initial begin
    logic [2:0] c;
    rst_n = 0;
    repeat (8) @(negedge ref_clk);
    rst_n = 1;
    word_q.push_back(16'h7127);
    rd();
    // Every enable, averaging and time code read back, with mode code 000 or 100 keeping the converter off
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      put({1'b0, ~c, c, c, ~c, c[0], 2'b00});
      word_q.push_back(cfg);
      rd();
      quiet();
    end
    for (int m = 1; m < 8; m++) if (m != 4) run(3'(m));
    lfsr = step(lfsr);
    host_u.xfer(0, 8'h07, lfsr[15:0], 1);
    word_q.push_back(lfsr[15:0]);
    host_u.xfer(1, 8'h07, 16'h0, 0);
    put(16'h8000 | lfsr[31:16]);
    word_q.push_back(16'h7127);
    rd();
    host_u.xfer(0, 8'h07, 16'h0, 0);
    word_q.push_back(16'h7FF8);
    host_u.xfer(1, 8'h07, 16'h0, 0);
    repeat (300) @(negedge ref_clk);
    results();
  end
endmodule : triple_channel_monitor_config_tb
